/* inc/mrc_defines.vh */
// constants for the reset source controller: offsets, fields, reset values, timing
`ifndef MRC_DEFINES_VH
`define MRC_DEFINES_VH
// register byte offsets on the ahb-lite slave
`define MRC_OFF_MP0 8'h00
`define MRC_OFF_MP1 8'h04
`define MRC_OFF_BANK 8'h08
`define MRC_OFF_PCL 8'h0C
`define MRC_OFF_WATCHDOG_SETTING 8'h10
`define MRC_OFF_STATUS 8'h14
`define MRC_OFF_INTERRUPT_CONTROL 8'h18
`define MRC_OFF_TIMER_CONTROL 8'h1C
`define MRC_OFF_PA 8'h20
`define MRC_OFF_PAC 8'h24
`define MRC_OFF_PB 8'h28
`define MRC_OFF_PBC 8'h2C
`define MRC_OFF_PC 8'h30
`define MRC_OFF_PCC 8'h34
`define MRC_OFF_PG 8'h38
`define MRC_OFF_PGC 8'h3C
`define MRC_OFF_EEPROM_CONTROL 8'h40
`define MRC_OFF_CTRL 8'h44
`define MRC_OFF_CAUSE 8'h48
// status field positions
`define MRC_ST_PDF 4
`define MRC_ST_TO 5
// control register field positions
`define MRC_CT_HALT 0
`define MRC_CT_CLRWDT 1
// reset values
`define MRC_RV_BANK 8'h00
`define MRC_RV_PCL 8'h00
`define MRC_RV_WATCHDOG_SETTING 8'h07
`define MRC_RV_INTERRUPT_CONTROL 6'h00
`define MRC_RV_TIMER_CONTROL 8'h08
`define MRC_RV_PORT8 8'hFF
`define MRC_RV_PORT3 3'h7
`define MRC_RV_PORT1 1'h1
`define MRC_RV_EEPROM_CONTROL 4'h8
`define MRC_RV_PTR_MSB 1'b1
// stack top pointer value
`define MRC_SP_TOP 2'h0
// timing: least dip duration in microseconds, clock rate in kHz
`define MRC_DIP_US 1000
`define MRC_CLK_KHZ 25000
`define MRC_DIP_CYCLES ((`MRC_DIP_US * `MRC_CLK_KHZ + 999) / 1000)
`endif

/* rtl/mrc_reset_source_controller.v */
// reset source controller: combines power-on, pin, supply-dip and watchdog resets
//
// The address map and the AHB-Lite register port are this design's own decisions.
`include "mrc_defines.vh"
// overview: every reset cause but power-on becomes a one-cycle event in the i_clk
// domain, and one register process then applies the per-type values.
// the pin and supply inputs come from outside the clock domain and go
// through two flip-flops before any logic looks at them.
// the dip filter counts on i_clk, which stands for the free time base;
// a user who stops i_clk in power-down must feed this block a clock
// that keeps running, or dips during power-down go unseen.
// the bus side is a plain ahb-lite slave with no wait states and an
// okay response on every transfer.
// a write that meets a reset, halt or clear-watchdog event in the same
// cycle is dropped: the event has priority over software.
// the stack pointer is not held here; only its load value and strobe
// leave the block, so the core keeps the pointer itself.
// the watchdog counter lives outside as well: it only sees clear pulses.
module mrc_reset_source_controller #(
    parameter DIP_CYCLES = `MRC_DIP_CYCLES
) (
    // clock and synchronous power-on reset
    input wire i_clk,
    input wire i_rst,
    // reset causes and core events; pin and supply are asynchronous
    input wire i_external_reset_pin_n,
    input wire i_supply_low,
    input wire i_cfg_dip_enable,
    input wire i_cfg_clk_rc,
    input wire i_watchdog_overflow,
    input wire i_halt_exec,
    input wire i_clrwdt_exec,
    // ahb-lite slave port
    input wire [31:0] i_haddr,
    input wire [1:0] i_htrans,
    input wire i_hwrite,
    input wire [2:0] i_hsize,
    input wire [31:0] i_hwdata,
    input wire i_hsel,
    input wire i_hready,
    // ahb-lite slave answer
    output reg [31:0] o_hrdata,
    output reg o_hreadyout,
    output reg o_hresp,
    // reset pulses toward core, stack, watchdog and timer
    output reg o_core_reset,
    output reg o_pc_clear,
    output reg o_sp_load,
    output reg [1:0] o_sp_value,
    output reg o_watchdog_clear,
    output reg o_prescaler_clear,
    // strap copy, power-down state and port direction mirrors
    output reg o_clk_sel_rc,
    output reg o_halted,
    output reg [7:0] o_port_a_dir,
    output reg [7:0] o_port_b_dir
);
    // synchronisers for pin and supply inputs
    reg pin_meta, pin_sync, low_meta, low_sync;
    // power-on marker: set by i_rst, cleared after first cycle
    reg por_pending;
    // dip filter counter and valid flag
    reg [31:0] dip_count;
    reg dip_valid;
    // pin reset edge detect
    reg pin_sync_d;
    // powered-down state
    reg halted;
    // register file
    reg [7:0] memory_pointer_zero, memory_pointer_one, bank_pointer, program_counter_low_byte;
    reg [7:0] watchdog_setting, timer_control;
    reg [5:0] status_flags, interrupt_control;
    reg [7:0] port_a_data, port_a_direction, port_b_data, port_b_direction;
    reg [2:0] port_c_data, port_c_direction;
    reg port_g_data, port_g_direction;
    reg [3:0] eeprom_control;
    // last cause: 1 pin or dip, 2 running time-out, 3 halted time-out
    reg [1:0] last_cause;
    // ahb data-phase state
    reg dp_write, dp_read;
    reg [7:0] dp_addr;
    // decoded reset events
    // dip filter event, gated again by the enable option
    wire dip_fire;
    // falling edge of the synchronised pin
    wire pin_fire;
    // time-out while running: full initialisation
    wire wdt_normal;
    // time-out while halted: pc and stack only
    wire wdt_halt;
    // pin or dip: full initialisation, flags kept
    wire full_reset;
    // low byte of the write data; upper bus bits are ignored
    wire [7:0] wr_byte;
    // a valid address phase for this slave
    wire ahb_take;

    // clock source is a strap: held only as the configuration says
    // no software path exists to change the clock source at run time
    always @(posedge i_clk) begin
        o_clk_sel_rc <= i_cfg_clk_rc;
    end

    // two-flop synchronisers, first stage read only by second
    // the pin resets to its idle high level so no false edge follows reset
    always @(posedge i_clk) begin
        if (i_rst) begin
            pin_meta <= 1'b1;
            pin_sync <= 1'b1;
            low_meta <= 1'b0;
            low_sync <= 1'b0;
            pin_sync_d <= 1'b1;
        end else begin
            pin_meta <= i_external_reset_pin_n;
            pin_sync <= pin_meta;
            low_meta <= i_supply_low;
            low_sync <= low_meta;
            pin_sync_d <= pin_sync;
        end
    end

    // dip filter: counts continuous low time on the free-running clock
    // the count stops one past the limit so a long dip gives one event
    // and the counter cannot wrap back to zero during a long brown-out
    always @(posedge i_clk) begin
        if (i_rst) begin
            dip_count <= 32'h0000_0000;
            dip_valid <= 1'b0;
        end else if (!low_sync || !i_cfg_dip_enable) begin
            // short dip or disabled detector is dropped
            dip_count <= 32'h0000_0000;
            dip_valid <= 1'b0;
        end else if (dip_count < DIP_CYCLES) begin
            dip_count <= dip_count + 32'h0000_0001;
            dip_valid <= 1'b0;
        end else begin
            // persisted over the least duration
            dip_valid <= ~dip_valid & (dip_count == DIP_CYCLES);
            dip_count <= dip_count + ((dip_count == DIP_CYCLES) ? 32'h0000_0001 : 32'h0000_0000);
        end
    end

    // decode of the reset causes; pin and dip outrank the watchdog so a
    // coinciding time-out cannot set the flag over a pin reset
    assign dip_fire = dip_valid & i_cfg_dip_enable;
    assign pin_fire = pin_sync_d & ~pin_sync;
    // priority: pin or dip beats watchdog
    assign full_reset = pin_fire | dip_fire;
    assign wdt_normal = i_watchdog_overflow & ~halted & ~full_reset;
    assign wdt_halt = i_watchdog_overflow & halted & ~full_reset;
    assign wr_byte = i_hwdata[7:0];
    assign ahb_take = i_hsel & i_hready & i_htrans[1];

    // power-on marker
    // keeps o_halted low in the first cycle after power-on release
    always @(posedge i_clk) begin
        if (i_rst) begin
            por_pending <= 1'b1;
        end else begin
            por_pending <= 1'b0;
        end
    end

    // ahb-lite address phase capture; always zero wait states, okay
    // the data phase is only remembered here; the write itself lands in
    // the register process at the end of the data phase
    always @(posedge i_clk) begin
        if (i_rst) begin
            dp_write <= 1'b0;
            dp_read <= 1'b0;
            dp_addr <= 8'h00;
            o_hreadyout <= 1'b1;
            o_hresp <= 1'b0;
        end else begin
            dp_write <= ahb_take & i_hwrite;
            dp_read <= ahb_take & ~i_hwrite;
            dp_addr <= i_haddr[7:0];
            o_hreadyout <= 1'b1;
            o_hresp <= 1'b0;
        end
    end

    // read data mux during data phase
    // loaded at the address phase edge so it stands for the whole data
    // phase and holds until the next read
    always @(posedge i_clk) begin
        if (i_rst) begin
            o_hrdata <= 32'h0000_0000;
        end else if (ahb_take && !i_hwrite) begin
            case (i_haddr[7:0])
                `MRC_OFF_MP0: o_hrdata <= {24'h00_0000, memory_pointer_zero};
                `MRC_OFF_MP1: o_hrdata <= {24'h00_0000, memory_pointer_one};
                `MRC_OFF_BANK: o_hrdata <= {24'h00_0000, bank_pointer};
                `MRC_OFF_PCL: o_hrdata <= {24'h00_0000, program_counter_low_byte};
                `MRC_OFF_WATCHDOG_SETTING: o_hrdata <= {24'h00_0000, watchdog_setting};
                `MRC_OFF_STATUS: o_hrdata <= {26'h000_0000, status_flags};
                `MRC_OFF_INTERRUPT_CONTROL: o_hrdata <= {26'h000_0000, interrupt_control};
                `MRC_OFF_TIMER_CONTROL: o_hrdata <= {24'h00_0000, timer_control};
                `MRC_OFF_PA: o_hrdata <= {24'h00_0000, port_a_data};
                `MRC_OFF_PAC: o_hrdata <= {24'h00_0000, port_a_direction};
                `MRC_OFF_PB: o_hrdata <= {24'h00_0000, port_b_data};
                `MRC_OFF_PBC: o_hrdata <= {24'h00_0000, port_b_direction};
                `MRC_OFF_PC: o_hrdata <= {29'h0000_0000, port_c_data};
                `MRC_OFF_PCC: o_hrdata <= {29'h0000_0000, port_c_direction};
                `MRC_OFF_PG: o_hrdata <= {31'h0000_0000, port_g_data};
                `MRC_OFF_PGC: o_hrdata <= {31'h0000_0000, port_g_direction};
                `MRC_OFF_EEPROM_CONTROL: o_hrdata <= {28'h000_0000, eeprom_control};
                `MRC_OFF_CTRL: o_hrdata <= {31'h0000_0000, halted};
                `MRC_OFF_CAUSE: o_hrdata <= {30'h0000_0000, last_cause};
                // unmapped reads as zero
                default: o_hrdata <= 32'h0000_0000;
            endcase
        end
    end

    // register file: per-reset-type loads, then software writes
    // priority: power-on, then pin or dip, then running time-out, then
    // halted time-out, then halt and clear-watchdog, then bus writes
    always @(posedge i_clk) begin
        if (i_rst) begin
            // power-on values
            // pointer top bit reads one; the other bits start at zero here
            memory_pointer_zero <= 8'h80;
            memory_pointer_one <= 8'h80;
            bank_pointer <= `MRC_RV_BANK;
            program_counter_low_byte <= `MRC_RV_PCL;
            watchdog_setting <= `MRC_RV_WATCHDOG_SETTING;
            status_flags <= 6'h00;
            interrupt_control <= `MRC_RV_INTERRUPT_CONTROL;
            timer_control <= `MRC_RV_TIMER_CONTROL;
            port_a_data <= `MRC_RV_PORT8;
            port_a_direction <= `MRC_RV_PORT8;
            port_b_data <= `MRC_RV_PORT8;
            port_b_direction <= `MRC_RV_PORT8;
            port_c_data <= `MRC_RV_PORT3;
            port_c_direction <= `MRC_RV_PORT3;
            port_g_data <= `MRC_RV_PORT1;
            port_g_direction <= `MRC_RV_PORT1;
            eeprom_control <= `MRC_RV_EEPROM_CONTROL;
            halted <= 1'b0;
            last_cause <= 2'h0;
        end else if (full_reset || wdt_normal) begin
            // pin, dip or normal timeout: same initialisation
            memory_pointer_zero[7] <= `MRC_RV_PTR_MSB;
            memory_pointer_one[7] <= `MRC_RV_PTR_MSB;
            bank_pointer <= `MRC_RV_BANK;
            program_counter_low_byte <= `MRC_RV_PCL;
            watchdog_setting <= `MRC_RV_WATCHDOG_SETTING;
            interrupt_control <= `MRC_RV_INTERRUPT_CONTROL;
            timer_control <= `MRC_RV_TIMER_CONTROL;
            port_a_data <= `MRC_RV_PORT8;
            port_a_direction <= `MRC_RV_PORT8;
            port_b_data <= `MRC_RV_PORT8;
            port_b_direction <= `MRC_RV_PORT8;
            port_c_data <= `MRC_RV_PORT3;
            port_c_direction <= `MRC_RV_PORT3;
            port_g_data <= `MRC_RV_PORT1;
            port_g_direction <= `MRC_RV_PORT1;
            eeprom_control <= `MRC_RV_EEPROM_CONTROL;
            halted <= 1'b0;
            if (wdt_normal) begin
                status_flags[`MRC_ST_TO] <= 1'b1;
                last_cause <= 2'h2;
            end else begin
                // flags left as they were
                last_cause <= 2'h1;
            end
        end else if (wdt_halt) begin
            // pc cleared and power-down left; flags both set, rest kept
            program_counter_low_byte <= `MRC_RV_PCL;
            memory_pointer_zero[7] <= `MRC_RV_PTR_MSB;
            memory_pointer_one[7] <= `MRC_RV_PTR_MSB;
            status_flags[`MRC_ST_TO] <= 1'b1;
            status_flags[`MRC_ST_PDF] <= 1'b1;
            halted <= 1'b0;
            last_cause <= 2'h3;
        end else if (i_halt_exec) begin
            // halt sets powerdown flag, clears timeout flag
            status_flags[`MRC_ST_PDF] <= 1'b1;
            status_flags[`MRC_ST_TO] <= 1'b0;
            halted <= 1'b1;
        end else if (i_clrwdt_exec) begin
            // clear-watchdog clears both flags
            status_flags[`MRC_ST_PDF] <= 1'b0;
            status_flags[`MRC_ST_TO] <= 1'b0;
        end else if (dp_write) begin
            // software writes only when no reset or core event is pending
            case (dp_addr)
                `MRC_OFF_MP0: memory_pointer_zero <= {`MRC_RV_PTR_MSB, wr_byte[6:0]};
                `MRC_OFF_MP1: memory_pointer_one <= {`MRC_RV_PTR_MSB, wr_byte[6:0]};
                `MRC_OFF_BANK: bank_pointer <= wr_byte;
                `MRC_OFF_PCL: program_counter_low_byte <= wr_byte;
                `MRC_OFF_WATCHDOG_SETTING: watchdog_setting <= wr_byte;
                // flag bits are hardware only; low bits writable
                `MRC_OFF_STATUS: status_flags[3:0] <= wr_byte[3:0];
                `MRC_OFF_INTERRUPT_CONTROL: interrupt_control <= wr_byte[5:0];
                `MRC_OFF_TIMER_CONTROL: timer_control <= wr_byte;
                `MRC_OFF_PA: port_a_data <= wr_byte;
                `MRC_OFF_PAC: port_a_direction <= wr_byte;
                `MRC_OFF_PB: port_b_data <= wr_byte;
                `MRC_OFF_PBC: port_b_direction <= wr_byte;
                `MRC_OFF_PC: port_c_data <= wr_byte[2:0];
                `MRC_OFF_PCC: port_c_direction <= wr_byte[2:0];
                `MRC_OFF_PG: port_g_data <= wr_byte[0];
                `MRC_OFF_PGC: port_g_direction <= wr_byte[0];
                `MRC_OFF_EEPROM_CONTROL: eeprom_control <= wr_byte[3:0];
                // halt or clear-watchdog request by software
                `MRC_OFF_CTRL: begin
                    if (wr_byte[`MRC_CT_HALT]) begin
                        halted <= 1'b1;
                        status_flags[`MRC_ST_PDF] <= 1'b1;
                        status_flags[`MRC_ST_TO] <= 1'b0;
                    end else if (wr_byte[`MRC_CT_CLRWDT]) begin
                        status_flags[`MRC_ST_PDF] <= 1'b0;
                        status_flags[`MRC_ST_TO] <= 1'b0;
                    end
                end
                default: begin
                end
            endcase
        end
    end

    // reset pulses toward core, stack and watchdog
    // every pulse lasts one cycle and is held high through power-on reset
    always @(posedge i_clk) begin
        if (i_rst) begin
            o_core_reset <= 1'b1;
            o_pc_clear <= 1'b1;
            o_sp_load <= 1'b1;
            o_sp_value <= `MRC_SP_TOP;
            o_watchdog_clear <= 1'b1;
            o_prescaler_clear <= 1'b1;
        end else begin
            // released one cycle after power-on; watchdog counts then
            o_core_reset <= full_reset | wdt_normal;
            o_pc_clear <= full_reset | wdt_normal | wdt_halt;
            o_sp_load <= full_reset | wdt_normal | wdt_halt;
            o_sp_value <= `MRC_SP_TOP;
            o_watchdog_clear <= full_reset | wdt_normal | wdt_halt | i_clrwdt_exec;
            o_prescaler_clear <= full_reset | wdt_normal;
        end
    end

    // mirrors for core and ports
    // registered copies so every output comes straight from a flip-flop
    always @(posedge i_clk) begin
        if (i_rst) begin
            o_halted <= 1'b0;
            o_port_a_dir <= `MRC_RV_PORT8;
            o_port_b_dir <= `MRC_RV_PORT8;
        end else begin
            o_halted <= halted & ~por_pending;
            o_port_a_dir <= port_a_direction;
            o_port_b_dir <= port_b_direction;
        end
    end
endmodule

/* verif/mrc_checker_asserts.sv */
// port checker for the reset source controller
module mrc_checker #(
    parameter int DIP_CYCLES = 25000
) (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_external_reset_pin_n,
    input wire logic i_supply_low,
    input wire logic i_cfg_dip_enable,
    input wire logic i_cfg_clk_rc,
    input wire logic i_watchdog_overflow,
    input wire logic i_halt_exec,
    input wire logic i_clrwdt_exec,
    input wire logic o_core_reset,
    input wire logic o_pc_clear,
    input wire logic o_sp_load,
    input wire logic [1:0] o_sp_value,
    input wire logic o_watchdog_clear,
    input wire logic o_prescaler_clear,
    input wire logic o_clk_sel_rc,
    input wire logic o_halted,
    input wire logic [7:0] o_port_a_dir,
    input wire logic [7:0] o_port_b_dir
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [15:0] dip_run; // enabled low-supply cycles in a row
    logic [3:0] recent; // cycles since a legal full-reset cause
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (i_rst);
    // track causes that may start a full reset
    always @(posedge i_clk) begin
        if (i_rst) begin
            dip_run <= 16'h0000;
            recent <= 4'h0;
        end else begin
            dip_run <= (i_supply_low && i_cfg_dip_enable) ? dip_run + 16'h0001 : 16'h0000;
            if (!i_external_reset_pin_n || i_watchdog_overflow || dip_run >= DIP_CYCLES)
                recent <= 4'h0;
            else if (recent != 4'hf)
                recent <= recent + 4'h1;
        end
    end
    // pin stays high long enough that no pin event is pending
    sequence s_pin_quiet;
        i_external_reset_pin_n [*5];
    endsequence
    sequence s_halt_wdt;
        i_watchdog_overflow && o_halted && !i_supply_low;
    endsequence
    a_post_reset: assert property ($fell(i_rst) |-> o_port_a_dir == 8'hff && o_port_b_dir == 8'hff
        && o_core_reset && o_pc_clear && o_watchdog_clear && o_prescaler_clear)
        else $error("power-on reset outputs wrong");
    a_sp_top: assert property (o_sp_load |-> o_sp_value == 2'h0)
        else $error("stack pointer not loaded with top");
    a_core_full_set: assert property (o_core_reset |-> o_pc_clear && o_sp_load && o_watchdog_clear && o_prescaler_clear)
        else $error("full reset missing a clear");
    a_cause_recent: assert property ($rose(o_core_reset) |-> recent <= 4'd6)
        else $error("full reset without a cause");
    a_halt_wdt_pc: assert property (s_pin_quiet ##0 s_halt_wdt |-> ##[1:3] (o_pc_clear && o_sp_load))
        else $error("halted time-out did not clear pc");
    a_halt_wdt_keep: assert property (s_pin_quiet ##0 s_halt_wdt |=> (!o_core_reset && !o_prescaler_clear) [*3])
        else $error("halted time-out did a full reset");
    a_wdt_normal: assert property (s_pin_quiet ##0 (i_watchdog_overflow && !o_halted)
        |-> ##[1:3] (o_core_reset && o_prescaler_clear))
        else $error("running time-out gave no full reset");
    a_halt_enters: assert property (i_halt_exec && !i_watchdog_overflow |-> ##[1:2] o_halted)
        else $error("halt did not enter power-down");
    a_clrwdt_clears: assert property (i_clrwdt_exec |-> ##[1:2] o_watchdog_clear)
        else $error("clear-watchdog gave no clear");
    a_clk_follow: assert property ($stable(i_cfg_clk_rc) [*3] |-> o_clk_sel_rc == i_cfg_clk_rc)
        else $error("clock select does not follow option");
endmodule

/* verif/mrc_core_model.sv */
// behavioural core: a program counter the reset outputs clear
module mrc_core_model (
    input wire logic i_clk,
    input wire logic i_pc_clear,
    input wire logic i_halted,
    output logic [7:0] o_pc
);
    timeunit 1ns;
    timeprecision 1ns;
    // counts while running, frozen in power-down, cleared on request
    initial o_pc = 8'h55;
    always @(posedge i_clk) begin
        if (i_pc_clear)
            o_pc <= 8'h00;
        else if (!i_halted)
            o_pc <= o_pc + 8'h01;
    end
endmodule

/* verif/tb_top.sv */
// self-checking bench for the reset source controller
`include "mrc_defines.vh"
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int DIP = 20; // shortened dip filter
    logic i_clk = 0, i_rst = 1, i_external_reset_pin_n = 1, i_supply_low = 0;
    logic i_cfg_dip_enable = 0, i_cfg_clk_rc = 0, i_hwrite = 0, i_hsel = 0;
    logic [2:0] ev = 3'h0; // pulses: 0 halt, 1 clear-watchdog, 2 overflow
    logic [1:0] i_htrans = 2'h0;
    logic [31:0] i_haddr = 0, i_hwdata = 0, o_hrdata;
    logic o_hreadyout, o_hresp, o_core_reset, o_pc_clear, o_sp_load, o_watchdog_clear;
    logic o_prescaler_clear, o_clk_sel_rc, o_halted;
    logic [1:0] o_sp_value;
    logic [7:0] o_port_a_dir, o_port_b_dir, pc;
    logic [31:0] rd_d; // scratch read data of write transfers
    int failures = 0, n_tests = 0, n_cr = 0, n_pc = 0, n_wc = 0, c0, c1;
    // rows: address, reset value, mask of bits the test writes and checks as kept
    logic [7:0] r_addr [14] = '{8'h08, 8'h0c, 8'h10, 8'h18, 8'h1c, 8'h20, 8'h24, 8'h28, 8'h2c,
        8'h30, 8'h34, 8'h38, 8'h3c, 8'h40};
    logic [7:0] r_rv [14] = '{8'h00, 8'h00, 8'h07, 8'h00, 8'h08, 8'hff, 8'hff, 8'hff, 8'hff,
        8'h07, 8'h07, 8'h01, 8'h01, 8'h08};
    logic [7:0] r_msk [14] = '{8'hff, 8'h00, 8'hff, 8'h00, 8'h00, 8'hff, 8'hff, 8'hff, 8'hff,
        8'h07, 8'h07, 8'h01, 8'h01, 8'h00};
    mrc_reset_source_controller #(.DIP_CYCLES(DIP)) dut_u (.i_clk, .i_rst, .i_external_reset_pin_n,
        .i_supply_low, .i_cfg_dip_enable, .i_cfg_clk_rc, .i_watchdog_overflow(ev[2]), .i_halt_exec(ev[0]),
        .i_clrwdt_exec(ev[1]), .i_haddr, .i_htrans, .i_hwrite, .i_hsize(3'h2), .i_hwdata, .i_hsel,
        .i_hready(o_hreadyout), .o_hrdata, .o_hreadyout, .o_hresp, .o_core_reset, .o_pc_clear,
        .o_sp_load, .o_sp_value, .o_watchdog_clear, .o_prescaler_clear, .o_clk_sel_rc, .o_halted,
        .o_port_a_dir, .o_port_b_dir);
    mrc_core_model core_u (.i_clk, .i_pc_clear(o_pc_clear), .i_halted(o_halted), .o_pc(pc));
    // 25 MHz clock
    initial forever #20 i_clk = ~i_clk;
    // count reset pulses seen at the ports
    always @(posedge i_clk) begin
        if (!i_rst) begin
            n_cr += o_core_reset;
            n_pc += o_pc_clear;
            n_wc += o_watchdog_clear;
        end
    end
    // compare, count, report
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            failures++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // wait for hready under a bound
    task automatic wait_ready;
        int k;
        k = 0;
        do begin
            @(posedge i_clk);
            k++;
        end while (o_hreadyout !== 1'b1 && k < 50);
        if (k >= 50) failures++;
    endtask
    // one single word transfer; called just past a rising edge
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
        i_hsel <= 1'b1;
        i_htrans <= 2'b10;
        i_hwrite <= w;
        i_haddr <= {24'h0000_00, a};
        wait_ready();
        i_htrans <= 2'b00;
        i_hwdata <= wd;
        wait_ready();
        rd = o_hrdata;
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
        logic [31:0] d;
        xfer(1'b0, a, 32'h0000_0000, d);
        chk(d & m, e);
    endtask
    // table loop: reset values, or written values kept
    task automatic check_rows(input logic kept);
        for (int i = 0; i < 14; i++) begin
            if (!kept) rd_chk(r_addr[i], '1, {24'h0000_00, r_rv[i]});
            else if (r_msk[i] != 0) rd_chk(r_addr[i], '1, {24'h0000_00, 8'h5a & r_msk[i]});
        end
    endtask
    task automatic write_rows;
        logic [31:0] d;
        for (int i = 0; i < 14; i++)
            if (r_msk[i] != 0) xfer(1'b1, r_addr[i], 32'h0000_005a, d);
    endtask
    task automatic fire(input int b);
        ev[b] <= 1'b1;
        @(posedge i_clk);
        ev[b] <= 1'b0;
    endtask
    // bounded wait for one more pulse
    task automatic wait_cnt(ref int c, input int n0);
        for (int k = 0; k < 30 && c == n0; k++) @(posedge i_clk);
        chk(c, n0 + 1);
    endtask
    task automatic dip(input int n);
        i_supply_low <= 1'b1;
        repeat (n) @(posedge i_clk);
        i_supply_low <= 1'b0;
        repeat (8) @(posedge i_clk);
    endtask
    task automatic finish_test;
        $display("comparisons %0d mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    initial begin
        #(40 * 5000);
        failures++;
        finish_test();
    end
    // main sequence
    initial begin
        repeat (3) @(posedge i_clk);
        i_rst <= 1'b0;
        @(posedge i_clk);
        check_rows(1'b0);
        rd_chk(`MRC_OFF_MP0, 32'h0000_0080, 32'h0000_0080);
        rd_chk(`MRC_OFF_STATUS, 32'h0000_0030, 32'h0000_0000);
        rd_chk(8'h7c, '1, 32'h0000_0000);
        chk(o_hresp, 1'b0);
        chk(o_clk_sel_rc, 1'b0);
        write_rows();
        chk(o_port_a_dir, 8'h5a);
        chk(o_port_b_dir, 8'h5a);
        fire(0);
        rd_chk(`MRC_OFF_STATUS, 32'h0000_0030, 32'h0000_0010);
        c0 = n_pc;
        c1 = n_cr;
        fire(2);
        wait_cnt(n_pc, c0);
        chk(pc < 8'h08, 1'b1);
        chk(n_cr, c1);
        rd_chk(`MRC_OFF_STATUS, 32'h0000_0030, 32'h0000_0030);
        check_rows(1'b1);
        c0 = n_wc;
        fire(1);
        wait_cnt(n_wc, c0);
        rd_chk(`MRC_OFF_STATUS, 32'h0000_0030, 32'h0000_0000);
        c0 = n_cr;
        fire(2);
        wait_cnt(n_cr, c0);
        rd_chk(`MRC_OFF_STATUS, 32'h0000_0030, 32'h0000_0020);
        check_rows(1'b0);
        write_rows();
        c0 = n_cr;
        i_external_reset_pin_n <= 1'b0;
        repeat (6) @(posedge i_clk);
        i_external_reset_pin_n <= 1'b1;
        wait_cnt(n_cr, c0);
        rd_chk(`MRC_OFF_STATUS, 32'h0000_0030, 32'h0000_0020);
        check_rows(1'b0);
        chk(o_port_a_dir, 8'hff);
        xfer(1'b1, `MRC_OFF_MP0, 32'h0000_0000, rd_d);
        rd_chk(`MRC_OFF_MP0, 32'h0000_00ff, 32'h0000_0080);
        c0 = n_cr;
        dip(DIP + 10);
        chk(n_cr, c0);
        i_cfg_dip_enable <= 1'b1;
        dip(DIP - 2);
        chk(n_cr, c0);
        write_rows();
        dip(DIP + 10);
        chk(n_cr, c0 + 1);
        check_rows(1'b0);
        // second power-on reset in mid-run: flags clear, ports input
        i_rst <= 1'b1;
        repeat (3) @(posedge i_clk);
        i_rst <= 1'b0;
        @(posedge i_clk);
        rd_chk(`MRC_OFF_STATUS, 32'h0000_0030, 32'h0000_0000);
        check_rows(1'b0);
        i_cfg_clk_rc <= 1'b1;
        repeat (2) @(posedge i_clk);
        chk(o_clk_sel_rc, 1'b1);
        finish_test();
    end
endmodule
bind mrc_reset_source_controller mrc_checker #(.DIP_CYCLES(DIP_CYCLES)) chk_u (.i_clk, .i_rst,
    .i_external_reset_pin_n, .i_supply_low, .i_cfg_dip_enable, .i_cfg_clk_rc, .i_watchdog_overflow,
    .i_halt_exec, .i_clrwdt_exec, .o_core_reset, .o_pc_clear, .o_sp_load, .o_sp_value,
    .o_watchdog_clear, .o_prescaler_clear, .o_clk_sel_rc, .o_halted, .o_port_a_dir, .o_port_b_dir);
